// >>> src/bhior_defs.vh
// Constants for the banked host I/O register window
// Notes on behaviour
// R1: Host sees only sixteen byte locations; banks share them to reach more registers.
// R2: Word at 0xE-0xF is the bank selector, visible in every bank.
// R3: Active-low byte-lane enables pick 8, 16 or 32-bit reads and writes.
// R4: Bank and offset layout is identical for 8, 16 and 32-bit host buses.
// R5: Host port is a simple ISA/EISA/local-bus style slave for config, status, packets.
// R6: Packet data locations push or pop frame bytes, not just store values.
// R7: Configuration bit 0 set means 16-bit async bus, clear means 8-bit.
// R8: At power-up configuration bit 0 is copied into power control bit 0.
// R9: On the 32-bit variant the narrow-bus select bit has no effect.
// R10: Core runs at 125 MHz; 25 MHz only when configuration bit 1 is set.
// R11: Configuration word comes from EEPROM word 6; station address from words 1-3.
// R12: Reserved locations read zero and ignore writes, with no side effects.
`ifndef BHIOR_DEFS_VH
`define BHIOR_DEFS_VH

// Word indices inside the sixteen byte window (byte offset / 2)
`define BHIOR_W_LOW 3'h0
`define BHIOR_W_MID 3'h1
`define BHIOR_W_HIGH 3'h2
`define BHIOR_W_PKT0 3'h4
`define BHIOR_W_PKT1 3'h5
`define BHIOR_W_BANKSEL 3'h7
// Byte offset where the packet data window starts
`define BHIOR_OFF_PKT 4'h8

// Bank numbers
`define BHIOR_BANK_BASE 5'h00
`define BHIOR_BANK_STATION 5'h02
`define BHIOR_BANK_LAST_STORED 5'h07
`define BHIOR_BANK_PACKET 5'h11

// Number of storage slots per bank in banks 0..7
`define BHIOR_WORDS_PER_BANK 5'h03
`define BHIOR_STORE_DEPTH 24

// EEPROM word addresses
`define BHIOR_EE_BASE 6'h00
`define BHIOR_EE_MAC_LOW 6'h01
`define BHIOR_EE_MAC_MID 6'h02
`define BHIOR_EE_MAC_HIGH 6'h03
`define BHIOR_EE_CONFIG 6'h06

// Configuration word and power control fields
`define BHIOR_CFG_NARROW_BIT 0
`define BHIOR_CFG_RATE_BIT 1
`define BHIOR_POWER_MGMT_CONTROL_REG_NARROW_BIT 0

// Reset values
`define BHIOR_RST_WORD 16'h0000
`define BHIOR_RST_BYTE 8'h00
`define BHIOR_RST_DATA32 32'h0000_0000

// Lane masks per effective host bus width
`define BHIOR_LANES_32 4'hF
`define BHIOR_LANES_16 4'h3
`define BHIOR_LANES_8 4'h1

`endif

// >>> src/bhior_regs.v
// Banked host I/O register window with EEPROM configuration capture
`timescale 1ns/1ps
`include "bhior_defs.vh"

module bhior_regs (
  input wire REF_CLK,
  input wire RSTN,
  input wire [3:0] HOST_ADDR,
  input wire [3:0] BYTE_LANE_ENABLES_N,
  input wire HOST_RD_N,
  input wire HOST_WR_N,
  input wire [31:0] HOST_DATA_IN,
  output reg [31:0] HOST_DATA_OUT,
  output reg HOST_DATA_OE,
  input wire BUS_VARIANT_32,
  input wire [5:0] EE_WORD_ADDR,
  input wire [15:0] EE_WORD_DATA,
  input wire EE_WORD_VALID,
  output reg CLOCK_RATE_25M,
  output reg BUS_IS_16BIT,
  output reg [31:0] TX_DATA,
  output reg [3:0] TX_BYTE_EN,
  output reg TX_PUSH,
  input wire [31:0] RX_DATA,
  output reg [3:0] RX_BYTE_EN,
  output reg RX_POP
);

  // Two-stage synchronisers for every host pin; first stage feeds only the second
  reg [3:0] addr_s1;
  reg [3:0] addr_s2;
  reg [3:0] be_n_s1;
  reg [3:0] be_n_s2;
  reg rd_n_s1;
  reg rd_n_s2;
  reg wr_n_s1;
  reg wr_n_s2;
  reg [31:0] din_s1;
  reg [31:0] din_s2;
  reg v32_s1;
  reg v32_s2;
  reg rd_n_d;
  reg wr_n_d;

  // Register state
  reg [15:0] store [0:`BHIOR_STORE_DEPTH-1];
  reg [15:0] bank_selector;
  reg [15:0] power_mgmt_control_reg;
  reg [15:0] eeprom_config_word;

  // Access decode
  wire rd_start;
  wire wr_start;
  wire [4:0] bank;
  reg [3:0] lane_mask;
  reg [3:0] base_addr;
  reg [3:0] lane_addr [0:3];
  reg [3:0] lane_ok;
  reg [31:0] next_rdata;
  reg [3:0] next_pkt_lanes;
  reg [31:0] next_tx_data;
  // Each process owns its loop index; a shared index would have two drivers
  // and would let the two combinational loops retrigger each other forever
  integer i;
  integer j;
  integer k;
  integer m;
  integer n;

  // Map a bank and word to a flat storage slot for banks 0..7
  // Bank 1 slots stay unused; a flat table keeps the index a single multiply
  function [4:0] slot;
    input [4:0] b;
    input [2:0] w;
    begin
      slot = b[2:0] * `BHIOR_WORDS_PER_BANK + {2'b00, w};
    end
  endfunction

  // Which word locations hold a stored register; all others but the selector, power control and packet words are reserved
  // Bank 0 holds only the base address and the pause threshold
  function stored;
    input [4:0] b;
    input [2:0] w;
    begin
      if (b == `BHIOR_BANK_BASE) begin
        stored = (w == `BHIOR_W_LOW) || (w == `BHIOR_W_HIGH);
      end else if (b >= `BHIOR_BANK_STATION && b <= `BHIOR_BANK_LAST_STORED) begin
        stored = (w <= `BHIOR_W_HIGH);
      end else begin
        stored = 1'b0;
      end
    end
  endfunction

  // Packet data window lives only in the packet bank
  function is_pkt;
    input [4:0] b;
    input [2:0] w;
    begin
      is_pkt = (b == `BHIOR_BANK_PACKET) && ((w == `BHIOR_W_PKT0) || (w == `BHIOR_W_PKT1));
    end
  endfunction

  // Power control sits at word 0 of the packet bank
  function is_power_mgmt_control_reg;
    input [4:0] b;
    input [2:0] w;
    begin
      is_power_mgmt_control_reg = (b == `BHIOR_BANK_PACKET) && (w == `BHIOR_W_LOW);
    end
  endfunction

  // Pin synchronisers
  // Address, lanes and data are not realigned to the strobe; the host settles them early
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_s1 <= 4'h0;
      addr_s2 <= 4'h0;
      be_n_s1 <= 4'hF;
      be_n_s2 <= 4'hF;
      rd_n_s1 <= 1'b1;
      rd_n_s2 <= 1'b1;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
      din_s1 <= `BHIOR_RST_DATA32;
      din_s2 <= `BHIOR_RST_DATA32;
      v32_s1 <= 1'b0;
      v32_s2 <= 1'b0;
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      addr_s1 <= HOST_ADDR;
      addr_s2 <= addr_s1;
      be_n_s1 <= BYTE_LANE_ENABLES_N;
      be_n_s2 <= be_n_s1;
      rd_n_s1 <= HOST_RD_N;
      rd_n_s2 <= rd_n_s1;
      wr_n_s1 <= HOST_WR_N;
      wr_n_s2 <= wr_n_s1;
      din_s1 <= HOST_DATA_IN;
      din_s2 <= din_s1;
      v32_s1 <= BUS_VARIANT_32;
      v32_s2 <= v32_s1;
      rd_n_d <= rd_n_s2;
      wr_n_d <= wr_n_s2;
    end
  end

  // One access per strobe: act on the falling edge of the synchronised strobe
  assign rd_start = rd_n_d && !rd_n_s2; // R5
  assign wr_start = wr_n_d && !wr_n_s2; // R5
  assign bank = bank_selector[4:0];

  // Effective width; the 32-bit variant overrides the narrow select
  // Until the configuration word arrives the narrow variant's port is 8-bit, as after reset
  always @* begin
    if (v32_s2) begin
      lane_mask = `BHIOR_LANES_32; // R9
      base_addr = {addr_s2[3:2], 2'b00};
    end else if (power_mgmt_control_reg[`BHIOR_POWER_MGMT_CONTROL_REG_NARROW_BIT]) begin
      lane_mask = `BHIOR_LANES_16; // R7
      base_addr = {addr_s2[3:1], 1'b0};
    end else begin
      lane_mask = `BHIOR_LANES_8; // R7
      base_addr = addr_s2;
    end
  end

  // Byte address carried by each lane; same map for every bus width
  // Lanes that wrap past 0xF are masked off by the width, so the wrap is harmless
  always @* begin
    for (m = 0; m < 4; m = m + 1) begin
      lane_addr[m] = base_addr + m[3:0]; // R4
      lane_ok[m] = lane_mask[m] && !be_n_s2[m]; // R3
    end
  end

  // Read data gathered lane by lane; reserved bytes read as zero
  // Lanes past the bus width or with their enable high stay zero
  always @* begin
    next_rdata = `BHIOR_RST_DATA32;
    next_pkt_lanes = 4'h0;
    next_tx_data = `BHIOR_RST_DATA32;
    for (k = 0; k < 4; k = k + 1) begin
      if (lane_ok[k]) begin
        if (lane_addr[k][3:1] == `BHIOR_W_BANKSEL) begin
          next_rdata[8*k +: 8] = lane_addr[k][0] ? bank_selector[15:8] :
                                 bank_selector[7:0]; // R2
        end else if (stored(bank, lane_addr[k][3:1])) begin
          next_rdata[8*k +: 8] = lane_addr[k][0] ?
                                 store[slot(bank, lane_addr[k][3:1])][15:8] :
                                 store[slot(bank, lane_addr[k][3:1])][7:0]; // R1
        end else if (is_power_mgmt_control_reg(bank, lane_addr[k][3:1])) begin
          next_rdata[8*k +: 8] = lane_addr[k][0] ? power_mgmt_control_reg[15:8] :
                                 power_mgmt_control_reg[7:0];
        end else if (is_pkt(bank, lane_addr[k][3:1])) begin
          // Packet byte position follows the byte offset inside the window
          next_pkt_lanes[lane_addr[k][1:0]] = 1'b1; // R6
          next_rdata[8*k +: 8] = RX_DATA[8*lane_addr[k][1:0] +: 8];
          next_tx_data[8*lane_addr[k][1:0] +: 8] = din_s2[8*k +: 8];
        end else begin
          next_rdata[8*k +: 8] = `BHIOR_RST_BYTE; // R12
        end
      end
    end
  end

  // Read port: data registered at strobe start, driven while strobe is held
  // OE follows the synchronised strobe, so it drops three clocks after the strobe rises
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HOST_DATA_OUT <= `BHIOR_RST_DATA32;
      HOST_DATA_OE <= 1'b0;
      RX_POP <= 1'b0;
      RX_BYTE_EN <= 4'h0;
    end else begin
      HOST_DATA_OE <= !rd_n_s2;
      RX_POP <= 1'b0;
      if (rd_start) begin
        HOST_DATA_OUT <= next_rdata;
        // Popping only on touched packet lanes keeps reserved reads side-effect free
        RX_POP <= |next_pkt_lanes; // R6
        RX_BYTE_EN <= next_pkt_lanes;
      end
    end
  end

  // Packet writes become one push toward the transmit queue
  // A write that touches no packet lane never pushes, so reserved writes stay silent
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_DATA <= `BHIOR_RST_DATA32;
      TX_BYTE_EN <= 4'h0;
      TX_PUSH <= 1'b0;
    end else begin
      TX_PUSH <= 1'b0;
      if (wr_start && (|next_pkt_lanes)) begin
        TX_DATA <= next_tx_data; // R6
        TX_BYTE_EN <= next_pkt_lanes;
        TX_PUSH <= 1'b1;
      end
    end
  end

  // Bank selector, shared by all banks
  // Only bits 4:0 pick the bank; the upper byte is kept for read-back alone
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bank_selector <= `BHIOR_RST_WORD;
    end else if (wr_start) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (lane_ok[i] && lane_addr[i][3:1] == `BHIOR_W_BANKSEL) begin
          if (lane_addr[i][0]) begin
            bank_selector[15:8] <= din_s2[8*i +: 8]; // R2
          end else begin
            bank_selector[7:0] <= din_s2[8*i +: 8]; // R2
          end
        end
      end
    end
  end

  // Banked storage; EEPROM loads come later in the block so they win a tie
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (j = 0; j < `BHIOR_STORE_DEPTH; j = j + 1) begin
        store[j] <= `BHIOR_RST_WORD;
      end
    end else begin
      if (wr_start) begin
        for (j = 0; j < 4; j = j + 1) begin
          if (lane_ok[j] && stored(bank, lane_addr[j][3:1])) begin // R12
            if (lane_addr[j][0]) begin
              store[slot(bank, lane_addr[j][3:1])][15:8] <= din_s2[8*j +: 8]; // R1
            end else begin
              store[slot(bank, lane_addr[j][3:1])][7:0] <= din_s2[8*j +: 8]; // R1
            end
          end
        end
      end
      if (EE_WORD_VALID) begin
        case (EE_WORD_ADDR)
          `BHIOR_EE_BASE: store[slot(`BHIOR_BANK_BASE, `BHIOR_W_LOW)] <= EE_WORD_DATA;
          `BHIOR_EE_MAC_LOW: store[slot(`BHIOR_BANK_STATION, `BHIOR_W_LOW)] <= EE_WORD_DATA; // R11
          `BHIOR_EE_MAC_MID: store[slot(`BHIOR_BANK_STATION, `BHIOR_W_MID)] <= EE_WORD_DATA; // R11
          `BHIOR_EE_MAC_HIGH: store[slot(`BHIOR_BANK_STATION, `BHIOR_W_HIGH)] <= EE_WORD_DATA; // R11
          default: ;
        endcase
      end
    end
  end

  // Power control: host writes upper bits, bit 0 only follows the EEPROM
  // Bit 0 is read-only to the host so software cannot override the loaded width
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      power_mgmt_control_reg <= `BHIOR_RST_WORD;
    end else begin
      if (wr_start) begin
        for (n = 0; n < 4; n = n + 1) begin
          if (lane_ok[n] && is_power_mgmt_control_reg(bank, lane_addr[n][3:1])) begin
            if (lane_addr[n][0]) begin
              power_mgmt_control_reg[15:8] <= din_s2[8*n +: 8];
            end else begin
              power_mgmt_control_reg[7:1] <= din_s2[8*n+1 +: 7];
            end
          end
        end
      end
      if (EE_WORD_VALID && EE_WORD_ADDR == `BHIOR_EE_CONFIG) begin
        power_mgmt_control_reg[`BHIOR_POWER_MGMT_CONTROL_REG_NARROW_BIT] <=
          EE_WORD_DATA[`BHIOR_CFG_NARROW_BIT]; // R8
      end
    end
  end

  // Configuration word; reset leaves the rate bit clear, so the core starts at 125 MHz
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      eeprom_config_word <= `BHIOR_RST_WORD; // R10
    end else if (EE_WORD_VALID && EE_WORD_ADDR == `BHIOR_EE_CONFIG) begin
      eeprom_config_word <= EE_WORD_DATA; // R11
    end
  end

  // Core clock rate taken straight from the held word, so the two cannot disagree
  always @* begin
    CLOCK_RATE_25M = eeprom_config_word[`BHIOR_CFG_RATE_BIT]; // R10
  end

  // Width status seen by the pad logic
  // Registered so the pad logic never sees a decode glitch while the strap settles
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_IS_16BIT <= 1'b0;
    end else begin
      BUS_IS_16BIT <= !v32_s2 && power_mgmt_control_reg[`BHIOR_POWER_MGMT_CONTROL_REG_NARROW_BIT]; // R9
    end
  end

endmodule

// >>> testbench/bhior_regs_asserts.sv
// Port checker for the banked host register window
`timescale 1ns/1ps
module bhior_regs_asserts (
  input wire REF_CLK,
  input wire RSTN,
  input wire HOST_RD_N,
  input wire HOST_WR_N,
  input wire [31:0] HOST_DATA_OUT,
  input wire HOST_DATA_OE,
  input wire BUS_VARIANT_32,
  input wire [5:0] EE_WORD_ADDR,
  input wire [15:0] EE_WORD_DATA,
  input wire EE_WORD_VALID,
  input wire CLOCK_RATE_25M,
  input wire BUS_IS_16BIT,
  input wire TX_PUSH,
  input wire RX_POP
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Config fetch, with the strap settled low first so the width bit counts
  sequence s_cfg;
    EE_WORD_VALID && EE_WORD_ADDR == 6'h06;
  endsequence
  sequence s_narrow_cfg;
    (!BUS_VARIANT_32) [*5] ##0 s_cfg;
  endsequence
  sequence s_rd_start;
    HOST_RD_N ##1 !HOST_RD_N;
  endsequence
  a_rate_from_cfg: assert property (s_cfg |=> CLOCK_RATE_25M == $past(EE_WORD_DATA[1]))
    else $error("rate flag not taken from config bit 1");
  a_rate_holds: assert property (!(EE_WORD_VALID && EE_WORD_ADDR == 6'h06) |=>
    $stable(CLOCK_RATE_25M)) else $error("rate flag moved without a config load");
  a_width_from_cfg: assert property (s_narrow_cfg |-> ##2
    BUS_IS_16BIT == $past(EE_WORD_DATA[0], 2)) else $error("bus width not from config bit 0");
  a_wide_ignores: assert property (BUS_VARIANT_32 [*5] |-> !BUS_IS_16BIT)
    else $error("narrow width flagged on the wide variant");
  a_oe_rises: assert property (s_rd_start |-> ##[1:3] HOST_DATA_OE)
    else $error("read data not driven in time");
  a_oe_drops: assert property (HOST_RD_N [*4] |-> !HOST_DATA_OE)
    else $error("data driven with no read strobe");
  a_push_pulse: assert property (TX_PUSH |-> !$past(HOST_WR_N, 2) ##1 !TX_PUSH)
    else $error("packet push without a write or too long");
  a_pop_pulse: assert property (RX_POP |-> HOST_DATA_OE ##1 !RX_POP)
    else $error("packet pop without a read or too long");
  a_dout_holds: assert property (HOST_RD_N [*3] |=> $stable(HOST_DATA_OUT))
    else $error("read data changed with no read");
endmodule
bind bhior_regs bhior_regs_asserts i_chk (.REF_CLK, .RSTN, .HOST_RD_N, .HOST_WR_N,
  .HOST_DATA_OUT, .HOST_DATA_OE, .BUS_VARIANT_32, .EE_WORD_ADDR, .EE_WORD_DATA,
  .EE_WORD_VALID, .CLOCK_RATE_25M, .BUS_IS_16BIT, .TX_PUSH, .RX_POP);

// >>> testbench/bhior_host.sv
// Host processor model driving the strobed register bus
`timescale 1ns/1ps
module bhior_host (
  input wire clk,
  output reg [3:0] addr,
  output reg [3:0] be_n,
  output reg rd_n,
  output reg wr_n,
  output reg [31:0] dout,
  input wire [31:0] din
);
  // Idle bus: strobes and lanes inactive
  initial begin
    addr = 4'h0;
    be_n = 4'hF;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dout = 32'h0;
  end
  // One access; address, lanes and data settle a cycle before the strobe,
  // since all of them pass the same two-flop synchroniser
  task access(input bit wr, input [3:0] a, input [3:0] ben, input [31:0] d,
    output [31:0] q);
    @(posedge clk);
    addr <= a;
    be_n <= ben;
    dout <= d;
    @(posedge clk);
    rd_n <= wr;
    wr_n <= !wr;
    repeat (6) @(posedge clk);
    q = din;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    be_n <= 4'hF;
    dout <= ~d; // Released data must not keep its last value
    repeat (4) @(posedge clk); // Strobe idle three clocks or more
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the banked host register window
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run = tests_run + 1; if ((got) !== (exp)) begin \
  fail_count = fail_count + 1; $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module tb;
  reg clk, rstn, v32, ee_v;
  reg [5:0] ee_a;
  reg [15:0] ee_d;
  reg [31:0] rx, q, tx_seen;
  reg [40:0] rows [0:13];
  wire [3:0] ha, ben, txbe, rxbe;
  wire rd_n, wr_n, oe, rate, w16, push, pop;
  wire [31:0] hdi, hdo, txd;
  integer fail_count = 0;
  integer tests_run = 0;
  integer pushes = 0;
  integer pops = 0;
  integer i;
  bhior_host host (.clk(clk), .addr(ha), .be_n(ben), .rd_n(rd_n), .wr_n(wr_n), .dout(hdi),
    .din(hdo));
  bhior_regs i_bhior_regs (.REF_CLK(clk), .RSTN(rstn), .HOST_ADDR(ha),
    .BYTE_LANE_ENABLES_N(ben), .HOST_RD_N(rd_n), .HOST_WR_N(wr_n), .HOST_DATA_IN(hdi),
    .HOST_DATA_OUT(hdo), .HOST_DATA_OE(oe), .BUS_VARIANT_32(v32), .EE_WORD_ADDR(ee_a),
    .EE_WORD_DATA(ee_d), .EE_WORD_VALID(ee_v), .CLOCK_RATE_25M(rate), .BUS_IS_16BIT(w16),
    .TX_DATA(txd), .TX_BYTE_EN(txbe), .TX_PUSH(push), .RX_DATA(rx), .RX_BYTE_EN(rxbe),
    .RX_POP(pop));
  // Reference clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Packet queue side: count pulses, keep the last pushed word
  always @(posedge clk) begin
    if (push) begin
      pushes = pushes + 1;
      tx_seen = txd;
    end
    if (pop)
      pops = pops + 1;
  end
  // Run is about 300 cycles; this limit is over thirty times that
  initial begin
    #400000;
    fail_count = fail_count + 1;
    results;
  end
  task results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One loader word, then time for the flags to settle
  task ee_load(input [5:0] a, input [15:0] d);
    @(posedge clk);
    ee_a <= a;
    ee_d <= d;
    ee_v <= 1'b1;
    @(posedge clk);
    ee_v <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Rows on the 32-bit variant: write flag, address, lane enables, data or expected read
  initial begin
    rows[0] = {1'b1, 4'hC, 4'h3, 32'h0002_0000};
    rows[1] = {1'b1, 4'h0, 4'h0, 32'h2222_1111};
    rows[2] = {1'b1, 4'h4, 4'h0, 32'h4444_3333};
    rows[3] = {1'b0, 4'h0, 4'h0, 32'h2222_1111};
    rows[4] = {1'b0, 4'h4, 4'h0, 32'h0000_3333};
    rows[5] = {1'b0, 4'hC, 4'h0, 32'h0002_0000};
    rows[6] = {1'b1, 4'hC, 4'h3, 32'h0001_0000};
    rows[7] = {1'b0, 4'h0, 4'h0, 32'h0000_0000};
    rows[8] = {1'b1, 4'h0, 4'h0, 32'hFFFF_FFFF};
    rows[9] = {1'b0, 4'h0, 4'h0, 32'h0000_0000};
    rows[10] = {1'b1, 4'hC, 4'h3, 32'h0002_0000};
    rows[11] = {1'b0, 4'h0, 4'h0, 32'h2222_1111};
    rows[12] = {1'b1, 4'h0, 4'hE, 32'h0000_00AA};
    rows[13] = {1'b0, 4'h0, 4'h0, 32'h2222_11AA};
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    v32 = 1'b0;
    ee_v = 1'b0;
    ee_a = 6'h00;
    ee_d = 16'h0000;
    rx = 32'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({oe, rate, w16, push, pop}, 5'b00000)
    ee_load(6'h06, 16'h0003);
    `CHK({rate, w16}, 2'b11)
    ee_load(6'h06, 16'h0000);
    `CHK({rate, w16}, 2'b00)
    ee_load(6'h06, 16'h0001);
    host.access(1'b1, 4'hE, 4'hC, 32'h0000_0011, q);
    host.access(1'b0, 4'h0, 4'hC, 32'h0, q);
    `CHK(q[15:0], 16'h0001)
    host.access(1'b1, 4'h8, 4'hC, 32'h0000_BEEF, q);
    `CHK({pushes, tx_seen[15:0], txbe}, {32'd1, 16'hBEEF, 4'h3})
    rx <= 32'h5A5A_C3C3;
    host.access(1'b0, 4'h8, 4'hC, 32'h0, q);
    `CHK({pops, q[15:0], rxbe}, {32'd1, 16'hC3C3, 4'h3})
    v32 <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(w16, 1'b0)
    for (i = 0; i < 14; i = i + 1) begin
      host.access(rows[i][40], rows[i][39:36], rows[i][35:32], rows[i][31:0], q);
      if (!rows[i][40])
        `CHK(q, rows[i][31:0])
    end
    ee_load(6'h01, 16'h1234);
    host.access(1'b0, 4'h0, 4'h0, 32'h0, q);
    `CHK(q, 32'h2222_1234)
    `CHK(pushes, 1)
    // Wide strap off and width bit clear: one lane, same map, slow core clock
    v32 <= 1'b0;
    ee_load(6'h06, 16'h0002);
    `CHK({rate, w16}, 2'b10)
    host.access(1'b0, 4'h1, 4'h0, 32'h0, q);
    `CHK(q, 32'h0000_0012)
    // Reset in mid-run clears read data, rate, width and bank
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({oe, rate, w16, hdo}, 35'h0)
    rstn <= 1'b1;
    host.access(1'b0, 4'hE, 4'h0, 32'h0, q);
    `CHK(q, 32'h0)
    results;
  end
endmodule
